// ==== rtl/pmc_pkg.sv ====
package pmc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] PMC_REG_MODE = 4'h0;
  localparam logic [3:0] PMC_REG_BANK = 4'h1;
  localparam logic [3:0] PMC_REG_IOSW = 4'h2;
  localparam logic [3:0] PMC_REG_CLK = 4'h3;
  localparam logic [3:0] PMC_REG_CAP = 4'h4;
  localparam logic [3:0] PMC_REG_TIMER = 4'h5;
  localparam logic [3:0] PMC_REG_STATUS = 4'h6;
  localparam logic [3:0] PMC_REG_DOMAIN = 4'h7;
  // Mode command codes
  localparam logic [1:0] PMC_CMD_ACTIVE = 2'h0;
  localparam logic [1:0] PMC_CMD_DEEP = 2'h1;
  localparam logic [1:0] PMC_CMD_RET = 2'h2;
  localparam logic [1:0] PMC_CMD_OFF = 2'h3;
  // Memory bank state codes
  localparam logic [1:0] PMC_BANK_ACTIVE = 2'h0;
  localparam logic [1:0] PMC_BANK_RETAIN = 2'h1;
  localparam logic [1:0] PMC_BANK_DOWN = 2'h2;
  localparam int PMC_NUM_BANKS = 7;
  // CPU clock select codes
  localparam logic [1:0] PMC_CPU_RC = 2'h0;
  localparam logic [1:0] PMC_CPU_XO = 2'h1;
  localparam logic [1:0] PMC_CPU_XO2X = 2'h2;
  localparam logic [1:0] PMC_CPU_PLL = 2'h3;
  // Clock register field positions
  localparam int PMC_CLK_CPU_LSB = 0;
  localparam int PMC_CLK_AON_RTC = 2;
  localparam int PMC_CLK_RTC_EXT = 3;
  localparam int PMC_CLK_XO_EN = 4;
  localparam int PMC_CLK_RTC_OUT = 5;
  localparam int PMC_CLK_PLL_SW = 6;
  localparam int PMC_CLK_DBL_EN = 7;
  localparam logic [7:0] PMC_CLK_RST = 8'h10;
  // Load capacitance: code n gives (n+1)*0.5pF, 0.5pF to 8pF
  localparam logic [3:0] PMC_CAP_RST = 4'h0;
  localparam logic [13:0] PMC_BANK_RST = 14'h0000;
  localparam logic [15:0] PMC_TIMER_RST = 16'h0000;
  // Crystal stabilisation time
  localparam int PMC_CLK_MHZ = 25;
  localparam int PMC_XO_SETTLE_US = 100;
  localparam int PMC_XO_SETTLE_CYC = PMC_XO_SETTLE_US * PMC_CLK_MHZ;
  // Sequencer state encodings for status readback
  typedef enum logic [2:0] {
    PMC_ST_ACTIVE = 3'b000,
    PMC_ST_DEEP = 3'b001,
    PMC_ST_RET = 3'b010,
    PMC_ST_OFF = 3'b011,
    PMC_ST_WAKE = 3'b100
  } pmc_state_e;
endpackage : pmc_pkg

// ==== rtl/pmc_clk_sw.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-source clock switch: deselect old, then select new
module pmc_clk_sw (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic want_b,
  input wire logic ok_b,
  output logic sel_a,
  output logic sel_b
);
  logic sel_a_r;
  logic sel_b_r;
  logic go_b;
  assign go_b = want_b && ok_b;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_a_r <= 1'b1;
      sel_b_r <= 1'b0;
    end else begin
      sel_a_r <= !go_b && !sel_b_r;
      sel_b_r <= go_b && !sel_a_r;
    end
  end
  assign sel_a = sel_a_r;
  assign sel_b = sel_b_r;
endmodule : pmc_clk_sw
`default_nettype wire

// ==== rtl/pmc_ctrl.sv ====
// Functional notes
// - Seven banks each active, retained or off
// - Deep sleep: only always-on domain powered
// - Sleep timer counts, expiry wakes domains
// - Wake pin or brownout also wakes
// - Retention sleep keeps selected banks
// - Active mode: all domains on
// - Off mode: everything off, always-on too; pll_en and doubler_en are not gated by off mode
// - Banks on core LDO active, retention asleep
// - IO switches configurable open during sleep
// - Five clock sources, low RC default
// - Always-on runs RC; software may select RTC
// - External 32.768kHz may replace RTC crystal
// - RTC clock routable to GPIO
// - CPU on RC after boot/wake; XO after settle
// - Crystal enabled by default after reset
// - Doubler gives 64MHz from crystal
// - PLL under hardware control by default
// - Load cap 0.5pF to 8pF, 0.5pF steps
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pmc_ctrl
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic wake_pin,
  input wire logic brownout,
  input wire logic xo_ready,
  input wire logic pll_hw_req,
  output logic always_on_domain_en,
  output logic switchable_domain_en,
  output logic [13:0] bank_state,
  output logic bank_supply_ret,
  output logic io_supply_switch_a,
  output logic io_supply_switch_b,
  output logic aon_clk_rtc,
  output logic rtc_ext_sel,
  output logic rtc_gpio_out_en,
  output logic xo_en,
  output logic doubler_en,
  output logic [1:0] cpu_clk_sel,
  output logic pll_en,
  output logic [3:0] crystal_load_cap
);
  // Pin synchronisers
  logic wake_s1_r;
  logic wake_s2_r;
  logic bo_s1_r;
  logic bo_s2_r;
  logic xo_s1_r;
  logic xo_s2_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      bo_s1_r <= 1'b0;
      bo_s2_r <= 1'b0;
      xo_s1_r <= 1'b0;
      xo_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_pin;
      wake_s2_r <= wake_s1_r;
      bo_s1_r <= brownout;
      bo_s2_r <= bo_s1_r;
      xo_s1_r <= xo_ready;
      xo_s2_r <= xo_s1_r;
    end
  end

  // Software registers
  logic [13:0] bank_r;
  logic [1:0] iosw_r;
  logic [7:0] clk_r;
  logic [3:0] cap_r;
  logic [15:0] timer_load_r;
  logic [1:0] cmd_r;
  logic cmd_go_r;
  logic [2:0] wake_cause_r;
  wire wr_mode = reg_wr && (reg_addr == PMC_REG_MODE);
  wire wr_bank = reg_wr && (reg_addr == PMC_REG_BANK);
  wire wr_iosw = reg_wr && (reg_addr == PMC_REG_IOSW);
  wire wr_clk = reg_wr && (reg_addr == PMC_REG_CLK);
  wire wr_cap = reg_wr && (reg_addr == PMC_REG_CAP);
  wire wr_timer = reg_wr && (reg_addr == PMC_REG_TIMER);
  wire rd_status = reg_rd && (reg_addr == PMC_REG_STATUS);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_r <= PMC_BANK_RST;
      iosw_r <= 2'h0;
      clk_r <= PMC_CLK_RST;
      cap_r <= PMC_CAP_RST;
      timer_load_r <= PMC_TIMER_RST;
      cmd_r <= PMC_CMD_ACTIVE;
      cmd_go_r <= 1'b0;
    end else begin
      cmd_go_r <= wr_mode;
      if (wr_mode) begin
        cmd_r <= reg_wdata[1:0];
      end
      if (wr_bank) begin
        bank_r <= reg_wdata[13:0];
      end
      if (wr_iosw) begin
        iosw_r <= reg_wdata[1:0];
      end
      if (wr_clk) begin
        clk_r <= reg_wdata[7:0];
      end
      if (wr_cap) begin
        cap_r <= reg_wdata[3:0];
      end
      if (wr_timer) begin
        timer_load_r <= reg_wdata[15:0];
      end
    end
  end

  // Power mode sequencer
  pmc_state_e state_r;
  pmc_state_e state_nxt;
  logic [15:0] timer_r;
  logic [15:0] timer_nxt;
  wire timer_exp = (timer_r == 16'h0001);
  wire wake_ev = timer_exp || wake_s2_r || bo_s2_r;
  wire sleeping = (state_r == PMC_ST_DEEP) || (state_r == PMC_ST_RET);

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    case (state_r)
      PMC_ST_ACTIVE: begin
        if (cmd_go_r) begin
          case (cmd_r)
            PMC_CMD_DEEP: state_nxt = PMC_ST_DEEP;
            PMC_CMD_RET: state_nxt = PMC_ST_RET;
            PMC_CMD_OFF: state_nxt = PMC_ST_OFF;
            default: state_nxt = PMC_ST_ACTIVE;
          endcase
          timer_nxt = timer_load_r;
        end
      end
      PMC_ST_DEEP, PMC_ST_RET: begin
        if (timer_r != 16'h0000) begin
          timer_nxt = timer_r - 16'h0001;
        end
        if (wake_ev) begin
          state_nxt = PMC_ST_WAKE;
          timer_nxt = 16'h0000;
        end
      end
      PMC_ST_WAKE: state_nxt = PMC_ST_ACTIVE;
      PMC_ST_OFF: state_nxt = PMC_ST_OFF;
      default: state_nxt = PMC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= PMC_ST_ACTIVE;
      timer_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_cause_r <= 3'h0;
    end else if (sleeping && wake_ev) begin
      wake_cause_r <= {bo_s2_r, wake_s2_r, timer_exp};
    end else if (rd_status) begin
      wake_cause_r <= 3'h0;
    end
  end

  // Domain and bank outputs
  logic aon_r;
  logic sw_dom_r;
  logic [13:0] bank_out_r;
  logic supply_ret_r;
  logic iosw_a_r;
  logic iosw_b_r;
  logic [13:0] bank_sleep;
  genvar g;
  generate
    for (g = 0; g < PMC_NUM_BANKS; g++) begin : g_bank
      // Retained banks keep contents, others power down in retention sleep
      assign bank_sleep[2*g+1:2*g] = (bank_r[2*g+1:2*g] == PMC_BANK_RETAIN) ?
          PMC_BANK_RETAIN : PMC_BANK_DOWN;
    end
  endgenerate

  wire next_off = (state_nxt == PMC_ST_OFF);
  wire next_sleep = (state_nxt == PMC_ST_DEEP) || (state_nxt == PMC_ST_RET);
  wire next_deep = (state_nxt == PMC_ST_DEEP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aon_r <= 1'b1;
      sw_dom_r <= 1'b1;
      bank_out_r <= PMC_BANK_RST;
      supply_ret_r <= 1'b0;
      iosw_a_r <= 1'b1;
      iosw_b_r <= 1'b1;
    end else begin
      aon_r <= !next_off;
      sw_dom_r <= !next_off && !next_sleep;
      if (next_off || next_deep) begin
        bank_out_r <= {PMC_NUM_BANKS{PMC_BANK_DOWN}};
      end else if (next_sleep) begin
        bank_out_r <= bank_sleep;
      end else begin
        // Every bank powered while awake; register picks the retained set
        bank_out_r <= {PMC_NUM_BANKS{PMC_BANK_ACTIVE}};
      end
      supply_ret_r <= next_sleep;
      iosw_a_r <= !next_off && !(next_sleep && iosw_r[0]);
      iosw_b_r <= !next_off && !(next_sleep && iosw_r[1]);
    end
  end

  // Clock selection
  logic xo_ok_r;
  logic [11:0] settle_r;
  localparam logic [11:0] SETTLE_MAX = 12'(PMC_XO_SETTLE_CYC);
  wire cpu_req_xo = (clk_r[PMC_CLK_CPU_LSB+1:PMC_CLK_CPU_LSB] != PMC_CPU_RC);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_r <= 12'h000;
      xo_ok_r <= 1'b0;
    end else if (!clk_r[PMC_CLK_XO_EN] || !xo_s2_r || sleeping) begin
      settle_r <= 12'h000;
      xo_ok_r <= 1'b0;
    end else if (settle_r != SETTLE_MAX) begin
      settle_r <= settle_r + 12'h001;
    end else begin
      xo_ok_r <= 1'b1;
    end
  end

  logic sel_rc;
  logic sel_fast;
  pmc_clk_sw u_cpu_sw (
    .clk(clk),
    .rst_n(rst_n),
    .want_b(cpu_req_xo && !sleeping),
    .ok_b(xo_ok_r),
    .sel_a(sel_rc),
    .sel_b(sel_fast)
  );
  logic sel_lrc;
  logic sel_rtc;
  pmc_clk_sw u_aon_sw (
    .clk(clk),
    .rst_n(rst_n),
    .want_b(clk_r[PMC_CLK_AON_RTC]),
    .ok_b(1'b1),
    .sel_a(sel_lrc),
    .sel_b(sel_rtc)
  );

  logic [1:0] cpu_sel_r;
  logic aon_rtc_r;
  logic rtc_ext_r;
  logic rtc_out_r;
  logic xo_en_r;
  logic dbl_r;
  logic pll_r;
  logic [3:0] cap_out_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_sel_r <= PMC_CPU_RC;
      aon_rtc_r <= 1'b0;
      rtc_ext_r <= 1'b0;
      rtc_out_r <= 1'b0;
      xo_en_r <= 1'b1;
      dbl_r <= 1'b0;
      pll_r <= 1'b0;
      cap_out_r <= PMC_CAP_RST;
    end else begin
      // Neither source selected for one cycle during a switch
      if (sel_fast) begin
        cpu_sel_r <= clk_r[PMC_CLK_CPU_LSB+1:PMC_CLK_CPU_LSB];
      end else if (sel_rc) begin
        cpu_sel_r <= PMC_CPU_RC;
      end
      aon_rtc_r <= sel_rtc && !sel_lrc;
      rtc_ext_r <= clk_r[PMC_CLK_RTC_EXT];
      rtc_out_r <= clk_r[PMC_CLK_RTC_OUT] && aon_r;
      xo_en_r <= clk_r[PMC_CLK_XO_EN] && !next_off && !next_sleep;
      dbl_r <= clk_r[PMC_CLK_DBL_EN] && xo_ok_r;
      pll_r <= clk_r[PMC_CLK_PLL_SW] ? (cpu_sel_r == PMC_CPU_PLL) :
          (pll_hw_req && !sleeping);
      cap_out_r <= cap_r;
    end
  end

  // Read data
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      PMC_REG_MODE: rd_mux = {30'h0, cmd_r};
      PMC_REG_BANK: rd_mux = {18'h0, bank_r};
      PMC_REG_IOSW: rd_mux = {30'h0, iosw_r};
      PMC_REG_CLK: rd_mux = {24'h0, clk_r};
      PMC_REG_CAP: rd_mux = {28'h0, cap_r};
      PMC_REG_TIMER: rd_mux = {16'h0, timer_r};
      PMC_REG_STATUS: rd_mux = {22'h0, wake_cause_r, xo_ok_r, cpu_sel_r, aon_rtc_r,
          state_r};
      PMC_REG_DOMAIN: rd_mux = {14'h0, bank_out_r, supply_ret_r, sw_dom_r, aon_r, 1'b0};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign always_on_domain_en = aon_r;
  assign switchable_domain_en = sw_dom_r;
  assign bank_state = bank_out_r;
  assign bank_supply_ret = supply_ret_r;
  assign io_supply_switch_a = iosw_a_r;
  assign io_supply_switch_b = iosw_b_r;
  assign aon_clk_rtc = aon_rtc_r;
  assign rtc_ext_sel = rtc_ext_r;
  assign rtc_gpio_out_en = rtc_out_r;
  assign xo_en = xo_en_r;
  assign doubler_en = dbl_r;
  assign cpu_clk_sel = cpu_sel_r;
  assign pll_en = pll_r;
  assign crystal_load_cap = cap_out_r;
endmodule : pmc_ctrl
`default_nettype wire

// ==== bench/pmc_ctrl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmc_ctrl_checker
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wake_pin,
  input wire logic brownout,
  input wire logic xo_ready,
  input wire logic always_on_domain_en,
  input wire logic switchable_domain_en,
  input wire logic bank_supply_ret,
  input wire logic aon_clk_rtc,
  input wire logic xo_en,
  input wire logic [1:0] cpu_clk_sel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_asleep;
    always_on_domain_en && !switchable_domain_en;
  endsequence
  sequence s_wake_held;
    (always_on_domain_en && !switchable_domain_en && (wake_pin || brownout)) [*3];
  endsequence
  a_active_all_on: assert property (switchable_domain_en |-> always_on_domain_en)
    else $error("active without always-on domain");
  a_active_core_ldo: assert property (switchable_domain_en |-> !bank_supply_ret)
    else $error("banks on retention supply while active");
  a_sleep_ret_ldo: assert property (s_asleep |-> bank_supply_ret)
    else $error("banks on core supply while asleep");
  a_off_all_down: assert property (!always_on_domain_en |-> !switchable_domain_en)
    else $error("switchable domain on in off mode");
  property p_off_stays;
    $fell(always_on_domain_en) |-> (!always_on_domain_en) [*8];
  endproperty
  property p_wake_on_rc;
    $rose(switchable_domain_en) |-> (cpu_clk_sel == PMC_CPU_RC) [*8];
  endproperty
  property p_xo_settled;
    $changed(cpu_clk_sel) && cpu_clk_sel == PMC_CPU_XO |-> $past(xo_ready, 8);
  endproperty
  property p_boot_default;
    $rose(rst_n) |-> xo_en && !aon_clk_rtc && cpu_clk_sel == PMC_CPU_RC;
  endproperty
  a_off_stays: assert property (p_off_stays)
    else $error("left off mode without reset");
  a_wake_on_rc: assert property (p_wake_on_rc)
    else $error("cpu not on rc after wake");
  a_xo_settled: assert property (p_xo_settled)
    else $error("cpu moved to crystal before it ran");
  a_boot_default: assert property (p_boot_default)
    else $error("clock defaults wrong after reset");
  a_wake_pin_brown: assert property (s_wake_held |-> ##[0:6] switchable_domain_en)
    else $error("no wake on pin or brownout");
endmodule : pmc_ctrl_checker
bind pmc_ctrl pmc_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n), .wake_pin(wake_pin),
  .brownout(brownout), .xo_ready(xo_ready), .always_on_domain_en(always_on_domain_en),
  .switchable_domain_en(switchable_domain_en), .bank_supply_ret(bank_supply_ret),
  .aon_clk_rtc(aon_clk_rtc), .xo_en(xo_en), .cpu_clk_sel(cpu_clk_sel));
`default_nettype wire

// ==== bench/tb_power_mode_clock_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_power_mode_clock_controller
  import pmc_pkg::*;
;
  logic clk, rst_n, reg_wr, reg_rd, wake_pin, brownout, xo_ready, pll_hw_req, rd_d;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, r;
  logic always_on_domain_en, switchable_domain_en, bank_supply_ret, io_supply_switch_a;
  logic io_supply_switch_b, aon_clk_rtc, rtc_ext_sel, rtc_gpio_out_en, xo_en, doubler_en, pll_en;
  logic [13:0] bank_state, bv, be;
  logic [1:0] cpu_clk_sel;
  logic [3:0] crystal_load_cap;
  logic [63:0] exp_q[$];
  logic [63:0] q;
  int miscompares, n_compared, n;
  pmc_ctrl uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_pin(wake_pin),
    .brownout(brownout), .xo_ready(xo_ready), .pll_hw_req(pll_hw_req),
    .always_on_domain_en(always_on_domain_en), .switchable_domain_en(switchable_domain_en),
    .bank_state(bank_state), .bank_supply_ret(bank_supply_ret),
    .io_supply_switch_a(io_supply_switch_a), .io_supply_switch_b(io_supply_switch_b),
    .aon_clk_rtc(aon_clk_rtc), .rtc_ext_sel(rtc_ext_sel), .rtc_gpio_out_en(rtc_gpio_out_en),
    .xo_en(xo_en), .doubler_en(doubler_en), .cpu_clk_sel(cpu_clk_sel), .pll_en(pll_en),
    .crystal_load_cap(crystal_load_cap));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Expected value and compare mask go to the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({m, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic wait_for(input logic on_xo, input int lim);
    n = 0;
    while (((on_xo ? (cpu_clk_sel == PMC_CPU_XO) : switchable_domain_en) !== 1'b1)
        && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      conclude();
    end
  endtask : wait_for
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      q = exp_q.pop_front();
      chk(reg_rdata & q[63:32], q[31:0] & q[63:32]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    seed = 32'd62;
    {rst_n, reg_wr, reg_rd, wake_pin, brownout, xo_ready, pll_hw_req} = 7'h00;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({bank_state, always_on_domain_en, switchable_domain_en, bank_supply_ret,
      io_supply_switch_a, io_supply_switch_b, xo_en, aon_clk_rtc, rtc_ext_sel,
      rtc_gpio_out_en, doubler_en, cpu_clk_sel}, 32'h00000DC0);
    rd(PMC_REG_CLK, 32'(PMC_CLK_RST), 32'hFFFFFFFF);
    rd(PMC_REG_TIMER, 32'h0, 32'hFFFFFFFF);
    rd(4'hC, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 16; i++) begin
      wr(PMC_REG_CAP, 32'(i));
      @(posedge clk);
      #1;
      chk(32'(crystal_load_cap), 32'(i));
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pll_hw_req <= ~i[0];
      repeat (3) @(posedge clk);
      #1;
      chk(32'(pll_en), {31'h0, ~i[0]});
    end
    wr(PMC_REG_CLK, 32'h000000BD);
    repeat (4) @(posedge clk);
    #1;
    // Doubler stays off until the crystal has settled
    chk({aon_clk_rtc, rtc_ext_sel, rtc_gpio_out_en, doubler_en, xo_en},
      32'h1D);
    repeat (50) @(posedge clk);
    #1;
    chk(32'(cpu_clk_sel), 32'(PMC_CPU_RC));
    @(posedge clk);
    xo_ready <= 1'b1;
    wait_for(1'b1, 3000);
    chk(32'(n >= 2500), 32'h1);
    chk(32'(doubler_en), 32'h1);
    rd(PMC_REG_STATUS, 32'h58, 32'h7F);
    for (int i = 0; i < 4; i++) begin
      wr(PMC_REG_CLK, 32'h000000BC | 32'(i + 2));
      repeat (6) @(posedge clk);
      #1;
      chk(32'(cpu_clk_sel), 32'((i + 2) % 4));
    end
    wr(PMC_REG_CLK, 32'h000000BD);
    r = xs();
    for (int b = 0; b < PMC_NUM_BANKS; b++) begin
      bv[2*b +: 2] = {1'b0, r[b]};
      be[2*b +: 2] = r[b] ? PMC_BANK_RETAIN : PMC_BANK_DOWN;
    end
    wr(PMC_REG_BANK, {18'h0, bv});
    wr(PMC_REG_IOSW, {30'h0, r[8:7]});
    wr(PMC_REG_TIMER, 32'd40);
    wr(PMC_REG_MODE, {30'h0, PMC_CMD_RET});
    @(posedge clk);
    #1;
    chk({always_on_domain_en, switchable_domain_en, bank_supply_ret, io_supply_switch_a,
      io_supply_switch_b, bank_state}, {3'b101, ~r[7], ~r[8], be});
    wait_for(1'b0, 200);
    chk(32'(n > 30 && n < 45), 32'h1);
    chk({cpu_clk_sel, bank_state, bank_supply_ret, io_supply_switch_a, io_supply_switch_b},
      32'h3);
    rd(PMC_REG_STATUS, 32'h80, 32'h380);
    rd(PMC_REG_STATUS, 32'h0, 32'h380);
    wr(PMC_REG_TIMER, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(PMC_REG_MODE, {30'h0, PMC_CMD_DEEP});
      @(posedge clk);
      #1;
      chk({always_on_domain_en, switchable_domain_en, bank_supply_ret, bank_state},
        {15'h0, 3'b101, 14'h2AAA});
      repeat (20) @(posedge clk);
      #1;
      chk(32'(switchable_domain_en), 32'h0);
      @(posedge clk);
      wake_pin <= (k == 0);
      brownout <= (k == 1);
      wait_for(1'b0, 20);
      chk(32'(n < 8), 32'h1);
      @(posedge clk);
      wake_pin <= 1'b0;
      brownout <= 1'b0;
      repeat (4) @(posedge clk);
      rd(PMC_REG_STATUS, (k == 0) ? 32'h100 : 32'h200, 32'h380);
    end
    wr(PMC_REG_MODE, {30'h0, PMC_CMD_ACTIVE});
    repeat (3) @(posedge clk);
    #1;
    chk({always_on_domain_en, switchable_domain_en, bank_supply_ret}, 32'h6);
    wr(PMC_REG_MODE, {30'h0, PMC_CMD_OFF});
    repeat (20) @(posedge clk);
    #1;
    chk({always_on_domain_en, switchable_domain_en}, 32'h0);
    conclude();
  end
endmodule : tb_power_mode_clock_controller
`default_nettype wire
